// ==== hw/tbd_defs.vh ====
// constants shared by the trace bucket detector files
`ifndef TBD_DEFS_VH
`define TBD_DEFS_VH

// detector mode encodings
`define TBD_MODE_SAMPLE 2'h0
`define TBD_MODE_POSPEAK 2'h1
`define TBD_MODE_NEGPEAK 2'h2
`define TBD_MODE_NORMAL 2'h3

// trace point count limits
`define TBD_MIN_POINTS 16'h0001
`define TBD_MAX_POINTS 16'h9c41

// width of divider operands and step count
`define TBD_DIV_WIDTH 32
`define TBD_DIV_STEPS 6'h20

// buffer depth
`define TBD_BUF_DEPTH 2

`endif

// ==== hw/tbd_pair_buffer.v ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "tbd_defs.vh"

module tbd_pair_buffer #(
    parameter W = 32
) (
    // clock and reset
    input wire clk,
    input wire rstSync_n,
    // filling side
    input wire inValid,
    input wire [W-1:0] inData,
    output wire inReady,
    // draining side
    output wire outValid,
    output wire [W-1:0] outData,
    input wire outReady
);

    reg [W-1:0] slot_ff [0:`TBD_BUF_DEPTH-1];
    reg wrPtr_ff;
    reg rdPtr_ff;
    reg [1:0] count_ff;
    wire push;
    wire pop;

    assign inReady = (count_ff != 2'h2);
    assign outValid = (count_ff != 2'h0);
    assign outData = slot_ff[rdPtr_ff];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            slot_ff[0] <= {W{1'b0}};
            slot_ff[1] <= {W{1'b0}};
            wrPtr_ff <= 1'b0;
            rdPtr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            if (push) begin
                slot_ff[wrPtr_ff] <= inData;
                wrPtr_ff <= ~wrPtr_ff;
            end
            if (pop) begin
                rdPtr_ff <= ~rdPtr_ff;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 2'h1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 2'h1;
            end
        end
    end

endmodule // tbd_pair_buffer

// ==== hw/tbd_trace_bucket_detector.v ====
// trace bucket detector: reduces envelope samples to one trace point per bucket
// Function
// [RULE1] Bucket frequency width is the span divided by the point count minus one.
// [RULE2] Bucket time width in samples is the sweep length divided by the point count minus one.
// [RULE3] Any point count from 1 to 40001 is accepted per sweep.
// [RULE4] Sample mode outputs the sample at the bucket midpoint and drops the rest.
// [RULE5] Positive peak mode outputs the largest sample of the bucket.
// [RULE6] Negative peak mode outputs the smallest sample of the bucket.
// [RULE7] Normal mode tracks max and min and calls a bucket noise when it rose and fell.
// [RULE8] A noise bucket with an odd number outputs a maximum.
// [RULE9] A noise bucket with an even number outputs its minimum.
// [RULE10] A bucket that only rose or only fell outputs its maximum regardless of parity.
// [RULE11] An odd noise bucket outputs the greater of the previous and current peaks.
// [RULE12] An even bucket outputting its minimum keeps its maximum for the next bucket.
// [RULE13] Buckets are numbered from one each sweep and the kept peak clears at sweep start.
// [RULE14] Exactly one point is emitted per bucket, strobed after its last sample.
`timescale 1ns/1ps
`include "tbd_defs.vh"

module tbd_trace_bucket_detector #(
    parameter W = 16
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // configuration, latched at sweep start
    input wire [1:0] detMode,
    input wire [15:0] pointCount,
    input wire [31:0] spanHz,
    input wire [31:0] sweepSamples,
    // sweep control and status
    input wire sweepStart,
    output wire sweepBusy,
    output wire sweepDone,
    output wire [31:0] bucketSpanHz,
    output wire [31:0] bucketSamples,
    // envelope sample stream
    input wire sampleValid,
    input wire [W-1:0] sampleData,
    output wire sampleReady,
    // trace point stream
    output wire pointValid,
    output wire [W-1:0] pointData,
    output wire [15:0] pointIndex,
    input wire pointReady
);

    localparam ST_IDLE = 2'h0;
    localparam ST_DIVSPAN = 2'h1;
    localparam ST_DIVTIME = 2'h2;
    localparam ST_RUN = 2'h3;

    reg rstMeta_ff;
    reg rstSync_ff;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    reg [1:0] state_ff, nxt_state;
    reg [1:0] mode_ff, nxt_mode;
    reg [15:0] pointTotal_ff, nxt_pointTotal;
    reg [15:0] divisor_ff, nxt_divisor;
    reg [31:0] sweepLen_ff, nxt_sweepLen;
    reg [5:0] divCnt_ff, nxt_divCnt;
    reg [16:0] divRem_ff, nxt_divRem;
    reg [31:0] divQ_ff, nxt_divQ;
    reg [31:0] spanQ_ff, nxt_spanQ;
    reg [31:0] bucketLen_ff, nxt_bucketLen;
    reg [31:0] sampCnt_ff, nxt_sampCnt;
    reg [15:0] bucketIdx_ff, nxt_bucketIdx;
    reg [W-1:0] maxV_ff, nxt_maxV;
    reg [W-1:0] minV_ff, nxt_minV;
    reg [W-1:0] midV_ff, nxt_midV;
    reg [W-1:0] prevV_ff, nxt_prevV;
    reg [W-1:0] savedPeak_ff, nxt_savedPeak;
    reg rose_ff, nxt_rose;
    reg fell_ff, nxt_fell;
    reg done_ff, nxt_done;

    // point result and buffer handshake
    reg [W-1:0] pointVal;
    reg pushPoint;
    wire bufInReady;

    // divider step
    reg [16:0] divTrial;
    reg [16:0] divDiff;

    // bucket statistics including the sample now taken
    reg [W-1:0] maxNow;
    reg [W-1:0] minNow;
    reg [W-1:0] midNow;
    reg roseNow;
    reg fellNow;
    reg firstSamp;
    reg lastSamp;
    reg [15:0] clampPts;
    wire take;

    assign take = (state_ff == ST_RUN) && sampleValid && bufInReady;
    assign sampleReady = (state_ff == ST_RUN) && bufInReady;
    assign sweepBusy = (state_ff != ST_IDLE);
    assign sweepDone = done_ff;
    assign bucketSpanHz = spanQ_ff;
    assign bucketSamples = bucketLen_ff;

    always @* begin
        divTrial = {divRem_ff[15:0], divQ_ff[31]};
        divDiff = divTrial - {1'b0, divisor_ff};
        firstSamp = (sampCnt_ff == 32'h0);
        lastSamp = (sampCnt_ff == bucketLen_ff - 32'h1);
        maxNow = (firstSamp || sampleData > maxV_ff) ? sampleData : maxV_ff;
        minNow = (firstSamp || sampleData < minV_ff) ? sampleData : minV_ff;
        // midpoint index is half the bucket length
        midNow = (sampCnt_ff == {1'b0, bucketLen_ff[31:1]}) ? sampleData : midV_ff; // see [RULE4]
        roseNow = !firstSamp && (rose_ff || sampleData > prevV_ff); // see [RULE7]
        fellNow = !firstSamp && (fell_ff || sampleData < prevV_ff); // see [RULE7]
        if (pointCount < `TBD_MIN_POINTS) begin
            clampPts = `TBD_MIN_POINTS;
        end else if (pointCount > `TBD_MAX_POINTS) begin
            clampPts = `TBD_MAX_POINTS;
        end else begin
            clampPts = pointCount; // see [RULE3]
        end
        case (mode_ff)
            `TBD_MODE_SAMPLE: pointVal = midNow; // see [RULE4]
            `TBD_MODE_POSPEAK: pointVal = maxNow; // see [RULE5]
            `TBD_MODE_NEGPEAK: pointVal = minNow; // see [RULE6]
            default: begin
                if (roseNow && fellNow) begin
                    if (bucketIdx_ff[0]) begin
                        // odd noise bucket: greater of kept and current peak
                        pointVal = (savedPeak_ff > maxNow) ? savedPeak_ff : maxNow; // see [RULE8] [RULE11]
                    end else begin
                        pointVal = minNow; // see [RULE9]
                    end
                end else begin
                    pointVal = maxNow; // see [RULE10]
                end
            end
        endcase
    end

    always @* begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_pointTotal = pointTotal_ff;
        nxt_divisor = divisor_ff;
        nxt_sweepLen = sweepLen_ff;
        nxt_divCnt = divCnt_ff;
        nxt_divRem = divRem_ff;
        nxt_divQ = divQ_ff;
        nxt_spanQ = spanQ_ff;
        nxt_bucketLen = bucketLen_ff;
        nxt_sampCnt = sampCnt_ff;
        nxt_bucketIdx = bucketIdx_ff;
        nxt_maxV = maxV_ff;
        nxt_minV = minV_ff;
        nxt_midV = midV_ff;
        nxt_prevV = prevV_ff;
        nxt_savedPeak = savedPeak_ff;
        nxt_rose = rose_ff;
        nxt_fell = fell_ff;
        nxt_done = 1'b0;
        pushPoint = 1'b0;
        if (sweepStart) begin
            // latch settings and start the span division
            nxt_state = ST_DIVSPAN;
            nxt_mode = detMode;
            nxt_pointTotal = clampPts;
            // a single point makes the whole sweep one bucket
            nxt_divisor = (clampPts == 16'h1) ? 16'h1 : clampPts - 16'h1; // see [RULE1] [RULE2]
            nxt_sweepLen = sweepSamples;
            nxt_divCnt = `TBD_DIV_STEPS;
            nxt_divRem = 17'h0;
            nxt_divQ = spanHz;
            nxt_sampCnt = 32'h0;
            nxt_bucketIdx = 16'h1; // see [RULE13]
            nxt_savedPeak = {W{1'b0}}; // see [RULE13]
            nxt_rose = 1'b0;
            nxt_fell = 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_state = ST_IDLE;
                end
                ST_DIVSPAN, ST_DIVTIME: begin
                    // restoring division, one quotient bit per cycle
                    if (divTrial >= {1'b0, divisor_ff}) begin
                        nxt_divRem = divDiff;
                        nxt_divQ = {divQ_ff[30:0], 1'b1};
                    end else begin
                        nxt_divRem = divTrial;
                        nxt_divQ = {divQ_ff[30:0], 1'b0};
                    end
                    nxt_divCnt = divCnt_ff - 6'h1;
                    if (divCnt_ff == 6'h1) begin
                        if (state_ff == ST_DIVSPAN) begin
                            nxt_spanQ = nxt_divQ; // see [RULE1]
                            nxt_state = ST_DIVTIME;
                            nxt_divCnt = `TBD_DIV_STEPS;
                            nxt_divRem = 17'h0;
                            nxt_divQ = sweepLen_ff;
                        end else begin
                            // a bucket holds at least one sample
                            nxt_bucketLen = (nxt_divQ == 32'h0) ? 32'h1 : nxt_divQ; // see [RULE2]
                            nxt_state = ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (take) begin
                        nxt_maxV = maxNow;
                        nxt_minV = minNow;
                        nxt_midV = midNow;
                        nxt_prevV = sampleData;
                        nxt_rose = roseNow;
                        nxt_fell = fellNow;
                        nxt_sampCnt = sampCnt_ff + 32'h1;
                        if (lastSamp) begin
                            pushPoint = 1'b1; // see [RULE14]
                            // current peak becomes the previous one for the next bucket
                            nxt_savedPeak = maxNow; // see [RULE12]
                            nxt_sampCnt = 32'h0;
                            nxt_rose = 1'b0;
                            nxt_fell = 1'b0;
                            nxt_bucketIdx = bucketIdx_ff + 16'h1;
                            if (bucketIdx_ff == pointTotal_ff) begin
                                nxt_state = ST_IDLE;
                                nxt_done = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            state_ff <= ST_IDLE;
            mode_ff <= `TBD_MODE_SAMPLE;
            pointTotal_ff <= `TBD_MIN_POINTS;
            divisor_ff <= 16'h1;
            sweepLen_ff <= 32'h0;
            divCnt_ff <= 6'h0;
            divRem_ff <= 17'h0;
            divQ_ff <= 32'h0;
            spanQ_ff <= 32'h0;
            bucketLen_ff <= 32'h1;
            sampCnt_ff <= 32'h0;
            bucketIdx_ff <= 16'h1;
            maxV_ff <= {W{1'b0}};
            minV_ff <= {W{1'b0}};
            midV_ff <= {W{1'b0}};
            prevV_ff <= {W{1'b0}};
            savedPeak_ff <= {W{1'b0}};
            rose_ff <= 1'b0;
            fell_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            pointTotal_ff <= nxt_pointTotal;
            divisor_ff <= nxt_divisor;
            sweepLen_ff <= nxt_sweepLen;
            divCnt_ff <= nxt_divCnt;
            divRem_ff <= nxt_divRem;
            divQ_ff <= nxt_divQ;
            spanQ_ff <= nxt_spanQ;
            bucketLen_ff <= nxt_bucketLen;
            sampCnt_ff <= nxt_sampCnt;
            bucketIdx_ff <= nxt_bucketIdx;
            maxV_ff <= nxt_maxV;
            minV_ff <= nxt_minV;
            midV_ff <= nxt_midV;
            prevV_ff <= nxt_prevV;
            savedPeak_ff <= nxt_savedPeak;
            rose_ff <= nxt_rose;
            fell_ff <= nxt_fell;
            done_ff <= nxt_done;
        end
    end

    // points wait here while the trace writer stalls
    tbd_pair_buffer #(
        .W(W + 16)
    ) pointBuf (
        .clk(clk),
        .rstSync_n(rstSync_ff),
        .inValid(pushPoint),
        .inData({bucketIdx_ff, pointVal}),
        .inReady(bufInReady),
        .outValid(pointValid),
        .outData({pointIndex, pointData}),
        .outReady(pointReady)
    );

endmodule // tbd_trace_bucket_detector

// ==== verif/tbd_detector_asserts.sv ====
// port assertions for the trace bucket detector
`timescale 1ns/1ps
module tbd_detector_asserts #(
    parameter W = 16
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // sweep control
    input wire sweepStart,
    input wire sweepBusy,
    input wire sweepDone,
    input wire [31:0] bucketSamples,
    // streams
    input wire sampleReady,
    input wire pointValid,
    input wire [W-1:0] pointData,
    input wire [15:0] pointIndex,
    input wire pointReady
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_hold;
        pointValid && !pointReady |=> pointValid && $stable(pointData) && $stable(pointIndex);
    endproperty
    a_hold: assert property (p_hold) else $error("point changed while stalled");
    property p_done; sweepDone |=> !sweepDone; endproperty
    a_done: assert property (p_done) else $error("done longer than one cycle");
    property p_busy; sweepStart |=> sweepBusy; endproperty
    a_busy: assert property (p_busy) else $error("busy missing after start");
    property p_divide; sweepStart |=> (!sampleReady) [*8]; endproperty
    a_divide: assert property (p_divide) else $error("sample taken before sizing");
    property p_min; bucketSamples != 32'h0; endproperty
    a_min: assert property (p_min) else $error("empty bucket size");
    property p_ready; sampleReady |-> sweepBusy; endproperty
    a_ready: assert property (p_ready) else $error("ready outside a sweep");
    property p_idx; pointValid |-> pointIndex != 16'h0; endproperty
    a_idx: assert property (p_idx) else $error("bucket number zero");
    property p_step;
        pointValid && pointReady ##1 pointValid
            |-> pointIndex == $past(pointIndex) + 16'h1 || pointIndex == 16'h1;
    endproperty
    a_step: assert property (p_step) else $error("bucket number skipped");
    property p_idle; sweepDone |-> !sampleReady; endproperty
    a_idle: assert property (p_idle) else $error("surplus sample accepted");
endmodule // tbd_detector_asserts

bind tbd_trace_bucket_detector tbd_detector_asserts #(.W(W)) u_asserts (
    .clk(clk), .rst_n(rst_n), .sweepStart(sweepStart), .sweepBusy(sweepBusy),
    .sweepDone(sweepDone), .bucketSamples(bucketSamples), .sampleReady(sampleReady),
    .pointValid(pointValid), .pointData(pointData), .pointIndex(pointIndex),
    .pointReady(pointReady)
);

// ==== verif/tbd_envelope_partner.sv ====
// envelope sample source and trace point sink
`timescale 1ns/1ps
module tbd_envelope_partner #(
    parameter W = 16
) (
    // clock
    input wire clk,
    // bench control
    input wire go,
    input wire hold,
    // sample stream
    output wire sampleValid,
    output wire [W-1:0] sampleData,
    input wire sampleReady,
    // point stream
    output wire pointReady
);
    // four buckets of four samples, one nibble each
    localparam [63:0] TAB = 64'h5726_3814_6253_9741;
    reg [4:0] idx;
    reg took;
    wire [3:0] nib;
    assign nib = TAB[63-4*idx[3:0] -: 4];
    assign sampleValid = go && (idx < 5'h10);
    // idle line shows the inverse, not the last word
    assign sampleData = sampleValid ? {{(W-4){1'b0}}, nib} : ~{{(W-4){1'b0}}, nib};
    assign pointReady = !hold;
    initial begin
        idx = 5'h0;
        took = 1'b0;
    end
    always @(posedge clk) begin
        took <= sampleValid && sampleReady;
    end
    always @(negedge clk) begin
        if (!go) begin
            idx <= 5'h0;
        end else if (took) begin
            idx <= idx + 5'h1;
        end
    end
endmodule // tbd_envelope_partner

// ==== verif/tbd_trace_bucket_detector_bench.sv ====
// self-checking bench for the trace bucket detector
`timescale 1ns/1ps
module tbd_trace_bucket_detector_bench;
    // expected points per mode: sample, max, min, normal
    localparam [63:0] EXP = 64'h2154_7869_2121_7189;
    localparam [63:0] PCS = 64'h0001_9c41_c350_0000;
    reg clk, rst_n, sweepStart, go, hold;
    reg [1:0] detMode;
    reg [15:0] pointCount;
    reg [31:0] spanHz, sweepSamples;
    wire sweepBusy, sweepDone, sampleValid, sampleReady, pointValid, pointReady;
    wire [31:0] bucketSpanHz, bucketSamples;
    wire [15:0] sampleData, pointData, pointIndex;
    integer mismatches, checked, k, m;

    tbd_trace_bucket_detector #(.W(16)) uut (
        .clk(clk), .rst_n(rst_n), .detMode(detMode), .pointCount(pointCount),
        .spanHz(spanHz), .sweepSamples(sweepSamples), .sweepStart(sweepStart),
        .sweepBusy(sweepBusy), .sweepDone(sweepDone), .bucketSpanHz(bucketSpanHz),
        .bucketSamples(bucketSamples), .sampleValid(sampleValid), .sampleData(sampleData),
        .sampleReady(sampleReady), .pointValid(pointValid), .pointData(pointData),
        .pointIndex(pointIndex), .pointReady(pointReady)
    );
    tbd_envelope_partner #(.W(16)) u_partner (
        .clk(clk), .go(go), .hold(hold), .sampleValid(sampleValid),
        .sampleData(sampleData), .sampleReady(sampleReady), .pointReady(pointReady)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task close_out;
        begin
            if (mismatches == 0 && checked > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // pulse start, then wait for sizing to finish
    task start(input [1:0] md, input [15:0] pc, input [31:0] sp, input [31:0] ss);
        begin
            @(negedge clk);
            detMode <= md;
            pointCount <= pc;
            spanHz <= sp;
            sweepSamples <= ss;
            sweepStart <= 1'b1;
            go <= 1'b0;
            @(negedge clk);
            sweepStart <= 1'b0;
            k = 0;
            while (sampleReady !== 1'b1 && k < 200) begin
                @(negedge clk);
                k = k + 1;
            end
        end
    endtask

    // four buckets of four samples, optional sink stall
    task sweep(input [1:0] md, input stall);
        begin
            start(md, 16'h4, 32'hbb8, 32'hc);
            chk(bucketSpanHz, 32'h3e8);
            chk(bucketSamples, 32'h4);
            chk({31'h0, sweepBusy}, 32'h1);
            go <= 1'b1;
            hold <= stall;
            if (stall) begin
                repeat (40) @(negedge clk);
                chk({31'h0, sampleReady}, 32'h0);
            end
            // a stalled sink is let go only after the head point was compared
            for (m = 0; m < 4; m = m + 1) begin
                k = 0;
                @(negedge clk);
                while (pointValid !== 1'b1 && k < 300) begin
                    @(negedge clk);
                    k = k + 1;
                end
                chk(pointData, EXP[63-16*md-4*m -: 4]);
                chk(pointIndex, m + 1);
                hold <= 1'b0;
            end
            // last point shows in the cycle after the last sample, with the done pulse
            chk({31'h0, sweepDone}, 32'h1);
            @(negedge clk);
            chk({30'h0, sweepBusy, sweepDone}, 32'h0);
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches = mismatches + 1;
        close_out;
    end

    initial begin
        rst_n = 1'b0;
        sweepStart = 1'b0;
        go = 1'b0;
        hold = 1'b0;
        detMode = 2'h0;
        pointCount = 16'h0;
        spanHz = 32'h0;
        sweepSamples = 32'h0;
        mismatches = 0;
        checked = 0;
        repeat (10) @(negedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        chk(bucketSamples, 32'h1);
        // one point, top count, over the top, zero
        for (m = 0; m < 4; m = m + 1) begin
            start(2'h1, PCS[63-16*m -: 16], 32'h13880, 32'h13880);
            chk(bucketSpanHz, (m == 1 || m == 2) ? 32'h2 : 32'h13880);
            chk(bucketSamples, (m == 1 || m == 2) ? 32'h2 : 32'h13880);
        end
        sweep(2'h0, 1'b0);
        sweep(2'h1, 1'b1);
        sweep(2'h2, 1'b0);
        sweep(2'h3, 1'b0);
        sweep(2'h3, 1'b1);
        close_out;
    end
endmodule // tbd_trace_bucket_detector_bench
